// *** atp_load.sv ***
// External load on the wave pin: resolves the pin level and counts it.
// Assumes one clock and a pull-down that holds a released pin low.
module atp_load
(
  input  wire         sys_clk,
  input  wire         clr,
  input  wire         pin,
  input  wire         pin_oe,
  output logic [15:0] high_cnt,
  output logic [7:0]  rise_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lvl_q;
  // A released pin falls to the pull-down, never to the last driven value.
  wire lvl = pin_oe ? pin : 1'b0;
  // High samples and rising edges are counted since the last clear.
  always @(posedge sys_clk)
  begin
    lvl_q <= lvl;
    high_cnt <= clr ? 16'h0000 : high_cnt + 16'(lvl);
    rise_cnt <= clr ? 8'h00 : rise_cnt + 8'(lvl && !lvl_q);
  end
endmodule // atp_load

// *** atp_map.vh ***
// Register map, field positions and reset values of the reload timer.
// Assumes an 8-bit register port addressed by the printed offsets.
`ifndef ATP_MAP_VH
`define ATP_MAP_VH

// Register offsets.
`define ATP_TIMER_CONTROL_STATUS 8'h0D
`define ATP_COUNTER_VALUE_HIGH   8'h0E
`define ATP_COUNTER_VALUE_LOW    8'h0F
`define ATP_RELOAD_VALUE_HIGH    8'h10
`define ATP_RELOAD_VALUE_LOW     8'h11
`define ATP_WAVE_OUTPUT_CONTROL  8'h12
`define ATP_WAVE_CONTROL_STATUS  8'h13
`define ATP_DUTY_VALUE_HIGH      8'h17
`define ATP_DUTY_VALUE_LOW       8'h18

// Fields of the control and status register.
`define ATP_CLK_SEL_HI   4
`define ATP_CLK_SEL_LO   3
`define ATP_WRAP_FLAG    2
`define ATP_WRAP_IRQ_EN  1
`define ATP_MATCH_IRQ_EN 0

// Counter clock selections.
`define ATP_CLK_OFF      2'h0
`define ATP_CLK_TIMEBASE 2'h1
`define ATP_CLK_CPU      2'h2

// Fields of the wave registers.
`define ATP_WAVE_POLARITY 1
`define ATP_MATCH_FLAG    0
`define ATP_WAVE_OE       0

// Reset values and counts.
`define ATP_RESET_BYTE 8'h00
`define ATP_RESET_12   12'h000
`define ATP_COUNT_TOP  12'hFFF
`define ATP_SLOW_DIV   32
`define ATP_SLOW_LAST  5'h1F

`endif

// *** atp_tb.sv ***
// Self-checking bench for atp_timer: register bus, clock sources and wave counts.
// Assumes the load model and the bound checker are compiled before it.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        timebase_tick = 1'b0;
  logic        slow_mode = 1'b0;
  logic        halt_mode = 1'b0;
  logic        active_halt_mode = 1'b0;
  wire  [7:0]  reg_rdata;
  wire         wave_output_pin, wave_output_pin_oe, wrap_irq, match_irq, wake_from_wait, wake_from_active_halt;
  wire  [15:0] high_cnt;
  wire  [7:0]  rise_cnt;
  logic        clr = 1'b0;
  logic        rd_d = 1'b0;
  logic [1:0]  cyc = 2'h0;
  logic [15:0] lf = 16'h0041;
  logic [15:0] n_wrap;
  logic [7:0]  exp_q[$];
  int          n_errors = 0;
  int          tests_run = 0;
  logic [7:0]  ofs[9] = '{8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h18, 8'h20};
  logic [7:0]  wm[9] = '{8'hE7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  rm[9] = '{8'h03, 8'h00, 8'h0F, 8'hFF, 8'h01, 8'h02, 8'h0F, 8'hFF, 8'h00};
  logic [1:0]  sel[8] = '{2, 1, 2, 2, 0, 3, 2, 1};
  logic        slw[8] = '{0, 0, 1, 0, 0, 0, 0, 0};
  logic        hlt[8] = '{0, 0, 0, 1, 0, 0, 0, 0};
  logic        ahl[8] = '{0, 0, 0, 0, 0, 0, 1, 1};
  int          mul[8] = '{1, 4, 32, 0, 0, 0, 0, 4};
  atp_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timebase_tick(timebase_tick),
    .slow_mode(slow_mode), .halt_mode(halt_mode), .active_halt_mode(active_halt_mode),
    .wave_output_pin(wave_output_pin), .wave_output_pin_oe(wave_output_pin_oe), .wrap_irq(wrap_irq),
    .match_irq(match_irq), .wake_from_wait(wake_from_wait), .wake_from_active_halt(wake_from_active_halt));
  atp_load u_load (.sys_clk(sys_clk), .clr(clr), .pin(wave_output_pin), .pin_oe(wave_output_pin_oe),
    .high_cnt(high_cnt), .rise_cnt(rise_cnt));
  // The clock inverts every half period of 50 ns.
  always #50 sys_clk = ~sys_clk;
  // Timebase ticks come every fourth cycle; wrap request cycles are counted per window.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 2'h1;
    timebase_tick <= (cyc == 2'h3);
    n_wrap <= clr ? 16'h0000 : n_wrap + 16'(wrap_irq);
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Read data stands only in the cycle after the strobe, so the oldest note is taken then.
  always @(posedge sys_clk)
  begin
    if (rd_d)
      chk(16'(reg_rdata), 16'(exp_q.pop_front()));
    rd_d <= reg_read;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_read <= 1'b0;
  endtask
  // Windows span whole periods, so counts do not depend on where they start.
  task automatic win(input int n, input int h, input int r, input int w);
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    if (h >= 0)
      chk(high_cnt, 16'(h));
    chk(16'(rise_cnt), 16'(r));
    chk(n_wrap, 16'(w));
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ofs[i])
      rd(ofs[i], 8'h00);
  endtask
  task automatic results();
    $display("Errors: %0d, checks: %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence; the second reset proves that random contents are cleared.
  initial
  begin
    do_reset();
    foreach (ofs[i])
    begin
      lf = lfsr(lf);
      wr(ofs[i], lf[7:0] & wm[i]);
      rd(ofs[i], lf[7:0] & wm[i] & rm[i]);
    end
    do_reset();
    // Period of 20 counts with a pulse of 5, high byte first.
    wr(8'h10, 8'h0F);
    wr(8'h11, 8'hEC);
    wr(8'h17, 8'h0F);
    wr(8'h18, 8'hF1);
    wr(8'h12, 8'h01);
    // The counter starts from zero, so no overflow may come before 4096 ticks.
    wr(8'h0D, 8'h10);
    win(4000, 0, 0, 0);
    repeat (100) @(posedge sys_clk);
    foreach (sel[i])
    begin
      slow_mode <= slw[i];
      halt_mode <= hlt[i];
      active_halt_mode <= ahl[i];
      wr(8'h0D, {3'h0, sel[i], 1'b0, mul[i] != 0, 1'b0});
      repeat (40 * mul[i] + 40) @(posedge sys_clk);
      win(mul[i] ? 40 * mul[i] : 200, mul[i] ? 10 * mul[i] : -1, mul[i] ? 2 : 0, 2 * mul[i]);
    end
    active_halt_mode <= 1'b0;
    wr(8'h0D, 8'h12);
    wr(8'h13, 8'h02);
    repeat (40) @(posedge sys_clk);
    win(40, 30, 2, 2);
    // A low clock enable drops the read strobe, so the read data stay at zero.
    clk_en <= 1'b0;
    rd(8'h12, 8'h00);
    clk_en <= 1'b1;
    wr(8'h13, 8'h00);
    wr(8'h17, 8'h0F);
    repeat (40) @(posedge sys_clk);
    win(40, 40, 0, 2);
    wr(8'h18, 8'hF1);
    repeat (40) @(posedge sys_clk);
    win(40, 10, 2, 2);
    // Compare mode: no wave, the match flag holds until read.
    wr(8'h12, 8'h00);
    wr(8'h0D, 8'h11);
    rd(8'h13, 8'h01);
    repeat (40) @(posedge sys_clk);
    win(40, 0, 0, 0);
    chk(16'(match_irq), 16'h0001);
    wr(8'h17, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h00);
    rd(8'h13, 8'h01);
    repeat (4200) @(posedge sys_clk);
    rd(8'h13, 8'h00);
    repeat (2) @(posedge sys_clk);
    results();
  end
  // The whole run takes about 1.3 ms; more than twice that means a hang.
  initial
  begin
    #3ms;
    n_errors++;
    results();
  end
endmodule // testbench

// *** atp_timer.v ***
// 12-bit auto-reload timer with one PWM channel and an
// output-compare mode, reached through byte registers.
// Assumes synchronous inputs, one clock and a master that
// never issues read and write strobes together. The power
// mode inputs and the timebase tick come from the clock and
// power controller of the surrounding chip.

`include "atp_map.vh"

module atp_timer
(
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  input  wire       timebase_tick,
  input  wire       slow_mode,
  input  wire       halt_mode,
  input  wire       active_halt_mode,
  output reg        wave_output_pin,
  output wire       wave_output_pin_oe,
  output wire       wrap_irq,
  output wire       match_irq,
  output wire       wake_from_wait,
  output wire       wake_from_active_halt
);

  // Software visible state.
  reg  [1:0]  counter_clock_select;
  reg         wrap_flag;
  reg         wrap_irq_enable;
  reg         match_irq_enable;
  reg  [11:0] counter_value;
  reg  [11:0] reload_value;
  reg  [11:0] duty_value;
  reg         wave_output_enable;
  reg         wave_polarity;
  reg         match_flag;

  // Internal state.
  reg  [11:0] duty_shadow;
  reg         compare_armed;
  reg         wave_level;
  reg  [4:0]  slow_count;

  // Combinational terms.
  reg         src_tick;
  reg         run_allowed;
  wire        wr_hit;
  wire        rd_hit;
  wire        counter_tick;
  wire        at_top;
  wire        overflow;
  wire [11:0] next_count;
  wire [11:0] compare_value;
  wire        match_event;
  reg  [7:0]  next_rdata;

  // Source of counter ticks before any slow-mode division.
  // The reserved code stops the counter like the off code, so a
  // stray write cannot make it run at an undefined rate.
  always @*
  begin
    case (counter_clock_select)
      `ATP_CLK_TIMEBASE: src_tick = timebase_tick;
      `ATP_CLK_CPU:      src_tick = 1'b1;
      default:           src_tick = 1'b0;
    endcase
  end

  // Power modes. Halt always stops the timer; active-halt
  // keeps it alive only on the timebase with wrap enabled,
  // since that is the only source still running then.
  // Wait mode has no port: the timer runs on through it.
  always @*
  begin
    if (halt_mode)
      run_allowed = 1'b0;
    else if (active_halt_mode)
      run_allowed = (counter_clock_select == `ATP_CLK_TIMEBASE)
                    && wrap_irq_enable;
    else
      run_allowed = 1'b1;
  end

  // In slow mode only every 32nd source tick reaches the counter.
  // The clock enable is folded in here, so a low enable stops the
  // counter, the shadow copy and both flags in the same cycle;
  // gating each process on its own would let one run ahead.
  assign counter_tick = clk_en && run_allowed && src_tick &&
                        (!slow_mode || slow_count == `ATP_SLOW_LAST);

  // Slow-mode prescaler; it idles at zero outside slow mode so
  // that entering slow mode always starts a full division.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      slow_count <= 5'h00;
    else if (clk_en)
    begin
      if (!slow_mode)
        slow_count <= 5'h00;
      else if (run_allowed && src_tick)
        slow_count <= slow_count + 5'h01;
    end
  end

  // Next counter value: increment, or reload after the top.
  // The reload value is used at the top only, so a new value
  // never cuts the period in progress short.
  assign at_top     = (counter_value == `ATP_COUNT_TOP);
  assign overflow   = counter_tick && at_top;
  assign next_count = at_top ? reload_value
                             : counter_value + 12'h001;

  // Compare operand: shadow in PWM mode, duty value otherwise.
  assign compare_value = wave_output_enable ? duty_shadow
                                            : duty_value;

  // Match on the value the counter is about to take. A zero
  // duty value never matches, and a half-written duty value
  // is locked out until its low byte arrives.
  assign match_event = counter_tick && compare_armed &&
                       (compare_value != `ATP_RESET_12) &&
                       (next_count == compare_value);

  // Register strobes.
  // A low clock enable drops a strobe entirely.
  assign wr_hit = clk_en && reg_write;
  assign rd_hit = clk_en && reg_read;

  // Counter. It starts from zero after reset.
  // The first period therefore runs a full 4096 ticks.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      counter_value <= `ATP_RESET_12;
    else if (counter_tick)
      counter_value <= next_count;
  end

  // Control register and its enables.
  // The status flag and the reserved bits ignore writes.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter_clock_select <= `ATP_CLK_OFF;
      wrap_irq_enable      <= 1'b0;
      match_irq_enable     <= 1'b0;
    end
    else if (wr_hit && reg_addr == `ATP_TIMER_CONTROL_STATUS)
    begin
      counter_clock_select <= reg_wdata[`ATP_CLK_SEL_HI:`ATP_CLK_SEL_LO];
      wrap_irq_enable      <= reg_wdata[`ATP_WRAP_IRQ_EN];
      match_irq_enable     <= reg_wdata[`ATP_MATCH_IRQ_EN];
    end
  end

  // Wrap flag. It drops at the next counter tick or on a read
  // of the status register. A new overflow in the same cycle
  // wins over both clears, so no event is lost.
  // Clearing on the next tick keeps it up for one counter tick interval.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wrap_flag <= 1'b0;
    else if (clk_en)
    begin
      if (overflow)
        wrap_flag <= 1'b1;
      else if (counter_tick)
        wrap_flag <= 1'b0;
      else if (rd_hit && reg_addr == `ATP_TIMER_CONTROL_STATUS)
        wrap_flag <= 1'b0;
    end
  end

  // Reload value, written a byte at a time.
  // A high byte written alone leaves a mixed value that the next
  // overflow loads; software should write both between overflows.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reload_value <= `ATP_RESET_12;
    else if (wr_hit && reg_addr == `ATP_RELOAD_VALUE_HIGH)
      reload_value[11:8] <= reg_wdata[3:0];
    else if (wr_hit && reg_addr == `ATP_RELOAD_VALUE_LOW)
      reload_value[7:0] <= reg_wdata;
  end

  // Duty value and compare lock. A high-byte write locks the
  // compare so that a torn value cannot fire a false match.
  // The lock resets open: the zero duty value never matches
  // anyway, so no write is needed before the timer starts.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_value    <= `ATP_RESET_12;
      compare_armed <= 1'b1;
    end
    else if (wr_hit && reg_addr == `ATP_DUTY_VALUE_HIGH)
    begin
      duty_value[11:8] <= reg_wdata[3:0];
      compare_armed    <= 1'b0;
    end
    else if (wr_hit && reg_addr == `ATP_DUTY_VALUE_LOW)
    begin
      duty_value[7:0] <= reg_wdata;
      compare_armed   <= 1'b1;
    end
  end

  // Shadow copy, taken at every overflow whatever the mode,
  // even when only the high byte has been rewritten.
  // Compare mode ignores it, but keeping it current lets a later
  // switch into PWM mode start from the last written value.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      duty_shadow <= `ATP_RESET_12;
    else if (overflow)
      duty_shadow <= duty_value;
  end

  // Output control and polarity registers.
  // Polarity is the only writable bit of the wave status register;
  // the match flag ignores writes and clears only on a read.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wave_output_enable <= 1'b0;
      wave_polarity      <= 1'b0;
    end
    else if (wr_hit && reg_addr == `ATP_WAVE_OUTPUT_CONTROL)
      wave_output_enable <= reg_wdata[`ATP_WAVE_OE];
    else if (wr_hit && reg_addr == `ATP_WAVE_CONTROL_STATUS)
      wave_polarity <= reg_wdata[`ATP_WAVE_POLARITY];
  end

  // Match flag; a match in the reading cycle wins over the clear.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      match_flag <= 1'b0;
    else if (clk_en)
    begin
      if (match_event)
        match_flag <= 1'b1;
      else if (rd_hit && reg_addr == `ATP_WAVE_CONTROL_STATUS)
        match_flag <= 1'b0;
    end
  end

  // Raw wave level. Overflow sets it and a match clears it; the
  // match wins, so a duty equal to the reload gives no pulse.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wave_level <= 1'b0;
    else if (clk_en)
    begin
      if (!wave_output_enable)
        wave_level <= 1'b0;
      else if (match_event)
        wave_level <= 1'b0;
      else if (overflow)
        wave_level <= 1'b1;
    end
  end

  // Pin data, registered after polarity so it never glitches.
  // With the enable clear the pin is released and reads low.
  // The extra stage delays the pin one cycle against the counter,
  // which no period or duty figure depends on.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wave_output_pin <= 1'b0;
    else if (clk_en)
      wave_output_pin <= wave_output_enable &&
                         (wave_level ^ wave_polarity);
  end

  // Push-pull drive only while the alternate function is on.
  assign wave_output_pin_oe = wave_output_enable;

  // Interrupt requests are level terms of flag and enable.
  // Clearing an enable silences its request from the next cycle.
  assign wrap_irq  = wrap_flag && wrap_irq_enable;
  assign match_irq = match_flag && match_irq_enable;

  // Wake terms. Both requests wake from wait; only wrap on the
  // timebase wakes from active-halt; nothing wakes from halt.
  // A flag left over from before halt must not wake it either.
  assign wake_from_wait = !halt_mode &&
                          (wrap_irq || match_irq);
  assign wake_from_active_halt = !halt_mode && wrap_irq &&
    (counter_clock_select == `ATP_CLK_TIMEBASE);

  // Read multiplexer. Reserved bits and unmapped offsets read
  // zero. The counter is not latched across its two byte reads,
  // so software must allow for a carry between them.
  // Reads have no side effect here; the flag clears sit with the flags.
  always @*
  begin
    next_rdata = `ATP_RESET_BYTE;
    case (reg_addr)
      `ATP_TIMER_CONTROL_STATUS:
        next_rdata = {3'h0, counter_clock_select, wrap_flag,
                      wrap_irq_enable, match_irq_enable};
      `ATP_COUNTER_VALUE_HIGH:
        next_rdata = {4'h0, counter_value[11:8]};
      `ATP_COUNTER_VALUE_LOW:
        next_rdata = counter_value[7:0];
      `ATP_RELOAD_VALUE_HIGH:
        next_rdata = {4'h0, reload_value[11:8]};
      `ATP_RELOAD_VALUE_LOW:
        next_rdata = reload_value[7:0];
      `ATP_WAVE_OUTPUT_CONTROL:
        next_rdata = {7'h00, wave_output_enable};
      `ATP_WAVE_CONTROL_STATUS:
        next_rdata = {6'h00, wave_polarity, match_flag};
      `ATP_DUTY_VALUE_HIGH:
        next_rdata = {4'h0, duty_value[11:8]};
      `ATP_DUTY_VALUE_LOW:
        next_rdata = duty_value[7:0];
      default:
        next_rdata = `ATP_RESET_BYTE;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  // Zero between reads keeps a shared read path quiet and lets
  // a stray strobe show up at once.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `ATP_RESET_BYTE;
    else if (clk_en)
      reg_rdata <= rd_hit ? next_rdata : `ATP_RESET_BYTE;
  end

endmodule // atp_timer

// *** atp_timer_asserts.sv ***
// Port checker for the reload timer, bound to every atp_timer.
// Assumes one clock domain; a low enable freezes the block, so checks pause.
module atp_timer_chk
(
  input wire       sys_clk,
  input wire       rst_n,
  input wire       clk_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  input wire       halt_mode,
  input wire       wave_output_pin,
  input wire       wave_output_pin_oe,
  input wire       wrap_irq,
  input wire       match_irq,
  input wire       wake_from_wait,
  input wire       wake_from_active_halt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n || !clk_en);
  // Pin control follows its register bit.
  a_oe_follow:
    assert property (reg_write && reg_addr == 8'h12 |=> wave_output_pin_oe == $past(reg_wdata[0]))
    else $error("pin enable does not follow its write");
  a_oe_release:
    assert property (!wave_output_pin_oe && !$past(wave_output_pin_oe) |-> !wave_output_pin)
    else $error("pin driven while released");
  a_rise_needs_oe:
    assert property ($rose(wave_output_pin) |-> $past(wave_output_pin_oe))
    else $error("pin rose without enable");
  // Requests are masked by their enables, so clearing one silences it from the next cycle.
  a_match_mask:
    assert property (reg_write && reg_addr == 8'h0D && !reg_wdata[0] |=> !match_irq)
    else $error("match request not masked");
  a_wrap_mask:
    assert property (reg_write && reg_addr == 8'h0D && !reg_wdata[1] |=> !wrap_irq)
    else $error("wrap request not masked");
  a_wake_wait:
    assert property (wake_from_wait == ((wrap_irq || match_irq) && !halt_mode))
    else $error("wait wake mismatch");
  a_wake_ahalt:
    assert property (wake_from_active_halt |-> wrap_irq && !halt_mode)
    else $error("active halt wake without wrap");
  // Read data stands one cycle only; reserved wave status bits read zero.
  a_rdata_idle:
    assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_wave_reserved:
    assert property ($past(reg_read && reg_addr == 8'h13) |-> reg_rdata[7:2] == 6'h00)
    else $error("reserved status bits set");
endmodule // atp_timer_chk
bind atp_timer atp_timer_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .halt_mode(halt_mode), .wave_output_pin(wave_output_pin), .wave_output_pin_oe(wave_output_pin_oe),
  .wrap_irq(wrap_irq), .match_irq(match_irq), .wake_from_wait(wake_from_wait),
  .wake_from_active_halt(wake_from_active_halt));
